//--- logic/slpc_top.sv
// sleep-mode controller: arms and enters low-power modes on the halt
// opcode, gates the clock domains per mode, qualifies wake-up sources,
// times the start-up and the fixed halt before the interrupt handler.
// assumes the core pulses i_halt_op for one cycle per halt opcode, the
// reset logic raises i_sys_reset_req for any reset source, and this block
// itself sits on an always-running clock.
//
// Contract
// - Sleep only when halt opcode executes with the arm bit set.
// - Mode field bits 3..1: idle, noise, power-down, power-save, standby.
// - Enabled interrupt wakes; stall four cycles after start-up; then handler.
// - Register file and RAM contents kept through sleep and wake.
// - Reset while asleep wakes to the reset vector, not after halt.
// - Idle stops only core and program-memory clocks.
// - Idle wakes on any enabled interrupt, external or internal.
// - Entering idle or noise mode with converter on starts a conversion.
// - Noise mode also stops peripheral clock; converter and async kept.
// - Noise mode wakes only on its listed sources.
// - Power-down stops main oscillator and all generated clocks.
// - Power-down wakes on resets, address match, upper level, lower lines.
// - Wake from power-down waits the fuse-selected start-up time.
// - Power-save keeps external timer running; its enabled events wake.
// - Standby keeps oscillator running and wakes in six cycles.
// - Comparator off bit powers comparator down, removing its wake.
`timescale 1ns/10ps
`default_nettype none
module slpc_top #(
    parameter int P_OSC_STARTUP_CK = 16384 // crystal start-up, cycles
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [slpc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [slpc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [slpc_pkg::DATA_W-1:0] o_rdata,
    // core and reset logic
    input wire logic i_halt_op,
    input wire logic i_sys_reset_req,
    output logic o_core_stall,
    output logic o_irq_take,
    output logic o_reset_vector,
    // static configuration from fuses and peripherals
    input wire logic [3:0] i_clock_source_fuses,
    input wire logic i_crystal_opt,
    input wire logic i_lowfreq_timer_ext_clock_sel,
    input wire logic i_global_irq_en,
    input wire logic i_adc_enabled,
    input wire logic [3:0] i_ext_irq_upper_is_level,
    // wake-up sources from pins (asynchronous)
    input wire logic [3:0] i_ext_irq_lower_lines,
    input wire logic [3:0] i_ext_irq_upper_lines,
    // wake-up sources from on-chip logic (enabled requests)
    input wire logic i_twi_addr_match,
    input wire logic i_timer2_ovf,
    input wire logic i_timer2_cmp,
    input wire logic i_mem_ready_irq,
    input wire logic i_adc_done_irq,
    input wire logic i_cmp_irq,
    input wire logic i_other_irq,
    // clock domain enables and side effects
    output logic o_cpu_clk_en,
    output logic o_flash_clk_en,
    output logic o_io_clk_en,
    output logic o_adc_clk_en,
    output logic o_asy_clk_en,
    output logic o_main_osc_en,
    output logic o_timer_osc_en,
    output logic o_adc_start,
    output logic o_cmp_power_en
);

    localparam logic [slpc_pkg::CNT_W-1:0] OSC_LOAD =
        slpc_pkg::CNT_W'(P_OSC_STARTUP_CK - 1);

    typedef struct packed {
        slpc_pkg::slpc_state_e state;
        logic arm;
        logic [2:0] mode;
        logic [2:0] slept_mode;
        logic cmp_off;
        logic [1:0] t2_mask;
        logic [slpc_pkg::CNT_W-1:0] cnt;
        logic [6:0] clk_en;
        logic [slpc_pkg::DATA_W-1:0] rdata;
        logic stall;
        logic irq_take;
        logic reset_vec;
        logic adc_start;
        logic cmp_pwr;
    } slpc_regs_s;

    slpc_regs_s regs_r;
    slpc_regs_s regs_nxt;

    logic [3:0] lower_s;
    logic [3:0] upper_s;

    // pin lines pass two flops; a level shorter than one cycle may be missed
    slpc_sync #(
        .W(8)
    ) u_pin_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async({i_ext_irq_upper_lines, i_ext_irq_lower_lines}),
        .o_sync({upper_s, lower_s})
    );

    // reserved codes never enter sleep
    function automatic logic mode_legal(input logic [2:0] m);
        mode_legal = (m == slpc_pkg::MODE_IDLE) ||
                     (m == slpc_pkg::MODE_NOISE) ||
                     (m == slpc_pkg::MODE_PDOWN) ||
                     (m == slpc_pkg::MODE_PSAVE) ||
                     (m == slpc_pkg::MODE_STANDBY);
    endfunction

    // standby without a crystal option falls back to power-down
    function automatic logic is_standby(input logic [2:0] m,
                                        input logic xtal);
        is_standby = (m == slpc_pkg::MODE_STANDBY) && xtal;
    endfunction

    // clock enables: {cpu, flash, io, adc, asy, main, tosc}
    function automatic logic [6:0] clk_fn(input slpc_pkg::slpc_state_e s,
                                          input logic [2:0] m,
                                          input logic as2,
                                          input logic xtal);
        logic [6:0] v;
        v = '0;
        unique case (s)
            slpc_pkg::ST_RUN: begin
                v = {4'hf, as2, 1'b1, as2};
            end
            slpc_pkg::ST_SLEEP: begin
                v[slpc_pkg::CK_ASY] = as2;
                v[slpc_pkg::CK_TOSC] = as2;
                if (m == slpc_pkg::MODE_IDLE) begin
                    v[slpc_pkg::CK_IO] = 1'b1;
                    v[slpc_pkg::CK_ADC] = 1'b1;
                    v[slpc_pkg::CK_MAIN] = 1'b1;
                end else if (m == slpc_pkg::MODE_NOISE) begin
                    v[slpc_pkg::CK_ADC] = 1'b1;
                    v[slpc_pkg::CK_MAIN] = 1'b1;
                end else if (m != slpc_pkg::MODE_PSAVE) begin
                    // power-down and standby stop every generated clock
                    v = '0;
                    v[slpc_pkg::CK_MAIN] = is_standby(m, xtal);
                end
            end
            slpc_pkg::ST_WAKE: begin
                // oscillator restarts; nothing downstream yet
                v[slpc_pkg::CK_MAIN] = 1'b1;
                v[slpc_pkg::CK_ASY] = as2;
                v[slpc_pkg::CK_TOSC] = as2;
            end
            slpc_pkg::ST_HALT: begin
                // peripherals run, core still held for the fixed stall
                v = {3'h1, 1'b1, as2, 1'b1, as2};
            end
            default: v = '0;
        endcase
        clk_fn = v;
    endfunction

    // wake qualification per mode; resets are handled separately
    function automatic logic wake_fn(input logic [2:0] m,
                                     input logic t2_any,
                                     input logic t2_asy,
                                     input logic cmp_ok);
        logic lines;
        lines = (|lower_s) || (|(upper_s & i_ext_irq_upper_is_level));
        unique case (m)
            slpc_pkg::MODE_IDLE:
                wake_fn = (|lower_s) || (|upper_s) || i_twi_addr_match ||
                          t2_any || i_mem_ready_irq || i_adc_done_irq ||
                          (i_cmp_irq && cmp_ok) || i_other_irq;
            slpc_pkg::MODE_NOISE:
                wake_fn = lines || i_twi_addr_match || t2_asy ||
                          i_mem_ready_irq || i_adc_done_irq;
            slpc_pkg::MODE_PSAVE:
                wake_fn = lines || i_twi_addr_match || t2_asy;
            default:
                wake_fn = lines || i_twi_addr_match;
        endcase
    endfunction

    // start-up delay before the fixed halt; none after idle or noise mode
    function automatic logic [slpc_pkg::CNT_W-1:0] startup_fn(
            input logic [2:0] m, input logic xtal, input logic [3:0] fuse);
        if (is_standby(m, xtal)) begin
            startup_fn = slpc_pkg::STANDBY_LOAD;
        end else if (fuse == slpc_pkg::FUSE_EXT_CLOCK) begin
            startup_fn = slpc_pkg::EXT_CLK_LOAD;
        end else begin
            startup_fn = OSC_LOAD;
        end
    endfunction

    // timer events count only when enabled and interrupts are on
    logic t2_any;
    logic t2_asy;
    assign t2_any = ((i_timer2_ovf && regs_r.t2_mask[0]) ||
                     (i_timer2_cmp && regs_r.t2_mask[1])) && i_global_irq_en;
    assign t2_asy = t2_any && i_lowfreq_timer_ext_clock_sel;

    // next-state logic: register port, sequencing and derived outputs
    always_comb begin
        logic [2:0] wmode;
        logic clock_kept;
        wmode = i_wdata[slpc_pkg::PSC_MODE_MSB:slpc_pkg::PSC_MODE_LSB];
        clock_kept = (regs_r.slept_mode == slpc_pkg::MODE_IDLE) ||
                     (regs_r.slept_mode == slpc_pkg::MODE_NOISE);
        regs_nxt = regs_r;
        regs_nxt.irq_take = 1'b0;
        regs_nxt.reset_vec = 1'b0;
        regs_nxt.adc_start = 1'b0;
        regs_nxt.rdata = '0;

        // register writes; the core is stalled while asleep anyway
        if (i_wr) begin
            unique case (i_addr)
                slpc_pkg::OFS_PSC: begin
                    regs_nxt.arm = i_wdata[slpc_pkg::PSC_ARM_BIT];
                    regs_nxt.mode = wmode;
                end
                slpc_pkg::OFS_AUX: begin
                    regs_nxt.cmp_off = i_wdata[slpc_pkg::AUX_CMP_OFF_BIT];
                    regs_nxt.t2_mask = {i_wdata[slpc_pkg::AUX_T2_CMP_BIT],
                                        i_wdata[slpc_pkg::AUX_T2_OVF_BIT]};
                end
                default: begin
                end
            endcase
        end

        // read data stands in the cycle after the strobe; reserved bits 0
        if (i_rd) begin
            unique case (i_addr)
                slpc_pkg::OFS_PSC: begin
                    regs_nxt.rdata = {4'h0, regs_r.mode, regs_r.arm};
                end
                slpc_pkg::OFS_AUX: begin
                    regs_nxt.rdata = {5'h00, regs_r.t2_mask, regs_r.cmp_off};
                end
                slpc_pkg::OFS_STAT: begin
                    regs_nxt.rdata = {1'b0, regs_r.slept_mode, regs_r.state};
                end
                default: regs_nxt.rdata = '0;
            endcase
        end

        unique case (regs_r.state)
            slpc_pkg::ST_RUN: begin
                // unarmed or reserved code: halt opcode is a no-op
                if (i_halt_op && regs_r.arm &&
                    mode_legal(regs_r.mode)) begin
                    regs_nxt.state = slpc_pkg::ST_SLEEP;
                    regs_nxt.slept_mode = regs_r.mode;
                    if (i_adc_enabled &&
                        (regs_r.mode == slpc_pkg::MODE_IDLE ||
                         regs_r.mode == slpc_pkg::MODE_NOISE)) begin
                        regs_nxt.adc_start = 1'b1;
                    end
                end
            end
            slpc_pkg::ST_SLEEP: begin
                if (i_sys_reset_req) begin
                    regs_nxt.state = slpc_pkg::ST_RUN;
                    regs_nxt.reset_vec = 1'b1;
                end else if (wake_fn(regs_r.slept_mode, t2_any, t2_asy,
                                     !regs_r.cmp_off)) begin
                    if (clock_kept) begin
                        regs_nxt.state = slpc_pkg::ST_HALT;
                        regs_nxt.cnt = slpc_pkg::HALT_LOAD;
                    end else begin
                        regs_nxt.state = slpc_pkg::ST_WAKE;
                        regs_nxt.cnt = startup_fn(regs_r.slept_mode,
                                                  i_crystal_opt,
                                                  i_clock_source_fuses);
                    end
                end
            end
            slpc_pkg::ST_WAKE: begin
                if (i_sys_reset_req) begin
                    regs_nxt.state = slpc_pkg::ST_RUN;
                    regs_nxt.reset_vec = 1'b1;
                end else if (regs_r.cnt == '0) begin
                    regs_nxt.state = slpc_pkg::ST_HALT;
                    regs_nxt.cnt = slpc_pkg::HALT_LOAD;
                end else begin
                    regs_nxt.cnt = regs_r.cnt - 1'b1;
                end
            end
            slpc_pkg::ST_HALT: begin
                if (i_sys_reset_req) begin
                    regs_nxt.state = slpc_pkg::ST_RUN;
                    regs_nxt.reset_vec = 1'b1;
                end else if (regs_r.cnt == '0) begin
                    // handler runs, then code after the halt opcode
                    regs_nxt.state = slpc_pkg::ST_RUN;
                    regs_nxt.irq_take = 1'b1;
                end else begin
                    regs_nxt.cnt = regs_r.cnt - 1'b1;
                end
            end
            default: regs_nxt.state = slpc_pkg::ST_RUN;
        endcase

        // derived outputs follow the next state so they leave flops aligned
        regs_nxt.clk_en = clk_fn(regs_nxt.state, regs_nxt.slept_mode,
                                 i_lowfreq_timer_ext_clock_sel,
                                 i_crystal_opt);
        // stall also blocks core writes, so the register file and RAM
        // keep their contents through sleep and wake
        regs_nxt.stall = (regs_nxt.state != slpc_pkg::ST_RUN);
        // comparator also off in the deep modes, where it cannot wake
        regs_nxt.cmp_pwr = !regs_nxt.cmp_off &&
            (regs_nxt.state == slpc_pkg::ST_RUN ||
             regs_nxt.slept_mode == slpc_pkg::MODE_IDLE ||
             regs_nxt.slept_mode == slpc_pkg::MODE_NOISE);
    end

    // state register; every output leaves from here
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            regs_r.state <= slpc_pkg::ST_RUN;
            regs_r.arm <= slpc_pkg::PSC_ARM_RST;
            regs_r.mode <= slpc_pkg::PSC_MODE_RST;
            regs_r.slept_mode <= slpc_pkg::PSC_MODE_RST;
            regs_r.cmp_off <= slpc_pkg::AUX_CMP_OFF_RST;
            regs_r.t2_mask <= slpc_pkg::AUX_T2_MASK_RST;
            regs_r.cnt <= '0;
            regs_r.clk_en <= 7'h7a;
            regs_r.rdata <= '0;
            regs_r.stall <= 1'b0;
            regs_r.irq_take <= 1'b0;
            regs_r.reset_vec <= 1'b0;
            regs_r.adc_start <= 1'b0;
            regs_r.cmp_pwr <= 1'b1;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // output mapping
    assign o_rdata = regs_r.rdata;
    assign o_core_stall = regs_r.stall;
    assign o_irq_take = regs_r.irq_take;
    assign o_reset_vector = regs_r.reset_vec;
    assign o_cpu_clk_en = regs_r.clk_en[slpc_pkg::CK_CPU];
    assign o_flash_clk_en = regs_r.clk_en[slpc_pkg::CK_FLASH];
    assign o_io_clk_en = regs_r.clk_en[slpc_pkg::CK_IO];
    assign o_adc_clk_en = regs_r.clk_en[slpc_pkg::CK_ADC];
    assign o_asy_clk_en = regs_r.clk_en[slpc_pkg::CK_ASY];
    assign o_main_osc_en = regs_r.clk_en[slpc_pkg::CK_MAIN];
    assign o_timer_osc_en = regs_r.clk_en[slpc_pkg::CK_TOSC];
    assign o_adc_start = regs_r.adc_start;
    assign o_cmp_power_en = regs_r.cmp_pwr;

endmodule
`default_nettype wire

//--- logic/slpc_pkg.sv
// package for the sleep-mode controller: register map, field layout,
// mode codes, state codes and wake-up cycle counts.
// assumes a single 100 MHz clock; all counts are in cycles of that clock.
package slpc_pkg;

    // register bus geometry
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // register offsets (indices on the plain register port)
    localparam logic [1:0] OFS_PSC = 2'h0;  // power_state_control
    localparam logic [1:0] OFS_AUX = 2'h1;  // comparator off, timer irq mask
    localparam logic [1:0] OFS_STAT = 2'h2; // state and latched mode

    // power_state_control fields
    localparam int PSC_ARM_BIT = 0;
    localparam int PSC_MODE_LSB = 1;
    localparam int PSC_MODE_MSB = 3;
    // auxiliary control fields
    localparam int AUX_CMP_OFF_BIT = 0;
    localparam int AUX_T2_OVF_BIT = 1;
    localparam int AUX_T2_CMP_BIT = 2;
    // status fields
    localparam int STAT_MODE_LSB = 4;

    // values after reset
    localparam logic PSC_ARM_RST = 1'h0;
    localparam logic [2:0] PSC_MODE_RST = 3'h0;
    localparam logic AUX_CMP_OFF_RST = 1'h0;
    localparam logic [1:0] AUX_T2_MASK_RST = 2'h0;

    // low_power_kind_field codes; 3'h4, 3'h5 and 3'h7 are reserved
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;

    // clock_source_fuses code for an external clock drive
    localparam logic [3:0] FUSE_EXT_CLOCK = 4'h0;

    // cycle counts
    localparam int CNT_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALT_CK = 4;        // stall before the handler
    localparam int STANDBY_WAKE_CK = 6; // oscillator kept running
    localparam int EXT_CLK_WAKE_CK = 6; // external clock start-up
    localparam logic [CNT_W-1:0] HALT_LOAD = CNT_W'(HALT_CK - 1);
    localparam logic [CNT_W-1:0] STANDBY_LOAD = CNT_W'(STANDBY_WAKE_CK - 1);
    localparam logic [CNT_W-1:0] EXT_CLK_LOAD = CNT_W'(EXT_CLK_WAKE_CK - 1);

    // controller states, one-hot
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_WAKE = 4'h4,
        ST_HALT = 4'h8
    } slpc_state_e;

    // clock enable vector positions
    localparam int CK_CPU = 6;
    localparam int CK_FLASH = 5;
    localparam int CK_IO = 4;
    localparam int CK_ADC = 3;
    localparam int CK_ASY = 2;
    localparam int CK_MAIN = 1;
    localparam int CK_TOSC = 0;

endpackage

//--- logic/slpc_sync.sv
// two flip-flop synchroniser for pin-level inputs.
// assumes inputs are quasi-static levels; pulses shorter than one clock
// period may be missed.
`timescale 1ns/10ps
`default_nettype none
module slpc_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } slpc_sync_s;

    slpc_sync_s sync_r;
    slpc_sync_s sync_nxt;

    // first stage feeds only the second stage
    always_comb begin
        sync_nxt.meta = i_async;
        sync_nxt.stable = sync_r.meta;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r.stable;

endmodule
`default_nettype wire

//--- tb/slpc_monitor.sv
// port checker for the sleep-mode controller
// assumes it is bound onto slpc_top; one clock domain
`timescale 1ns/10ps
`default_nettype none
module slpc_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // inputs watched
    input wire logic [slpc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [slpc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_halt_op,
    input wire logic i_sys_reset_req,
    input wire logic i_adc_enabled,
    input wire logic i_crystal_opt,
    // outputs watched
    input wire logic o_core_stall,
    input wire logic o_irq_take,
    input wire logic o_reset_vector,
    input wire logic o_cpu_clk_en,
    input wire logic o_io_clk_en,
    input wire logic o_adc_clk_en,
    input wire logic o_main_osc_en,
    input wire logic o_adc_start
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [3:0] psc_r;
    logic [2:0] ent_r;
    logic rsv, take;
    // shadow of the control register; mode kept at entry since sw may
    // rewrite the register while asleep
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            psc_r <= 4'h0;
            ent_r <= 3'h0;
        end else begin
            if (i_wr && i_addr == slpc_pkg::OFS_PSC) begin
                psc_r <= i_wdata[3:0];
            end
            if (i_halt_op && !o_core_stall) begin
                ent_r <= psc_r[3:1];
            end
        end
    end
    // reserved codes 4, 5 and 7
    assign rsv = psc_r[3] & ~(psc_r[2] & ~psc_r[1]);
    assign take = i_halt_op & ~o_core_stall & ~i_sys_reset_req & psc_r[0];

    property p_unarmed;
        i_halt_op && !o_core_stall && !psc_r[0] |=> !o_core_stall;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("halt without arm caused sleep");
    property p_enter;
        take && !rsv |=> o_core_stall;
    endproperty
    a_enter: assert property (p_enter)
        else $error("armed halt did not sleep");
    property p_reserved;
        take && rsv |=> !o_core_stall;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved mode entered sleep");
    property p_idle;
        $rose(o_core_stall) && ent_r == slpc_pkg::MODE_IDLE
            |-> !o_cpu_clk_en && o_io_clk_en && o_adc_clk_en;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle clock gating wrong");
    property p_noise;
        $rose(o_core_stall) && ent_r == slpc_pkg::MODE_NOISE
            |-> !o_cpu_clk_en && !o_io_clk_en && o_adc_clk_en;
    endproperty
    a_noise: assert property (p_noise)
        else $error("noise mode clock gating wrong");
    property p_pdown;
        $rose(o_core_stall) && ent_r == slpc_pkg::MODE_PDOWN
            |-> !o_main_osc_en && !o_adc_clk_en;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down left clocks running");
    property p_standby;
        $rose(o_core_stall) && ent_r == slpc_pkg::MODE_STANDBY
            && i_crystal_opt |-> o_main_osc_en;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby stopped the oscillator");
    property p_adc_start;
        $rose(o_core_stall) && ent_r[2:1] == 2'h0 && i_adc_enabled
            |-> o_adc_start;
    endproperty
    a_adc_start: assert property (p_adc_start)
        else $error("no conversion start on entry");
    property p_irq;
        o_irq_take |-> !o_core_stall && $past(o_core_stall, 4);
    endproperty
    a_irq: assert property (p_irq)
        else $error("handler taken without halt cycles");
    property p_reset;
        o_core_stall && i_sys_reset_req |=> o_reset_vector && !o_core_stall;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset during sleep missed reset vector");
    property p_osc;
        o_cpu_clk_en || o_io_clk_en |-> o_main_osc_en;
    endproperty
    a_osc: assert property (p_osc)
        else $error("clocked domain without oscillator");
endmodule
`default_nettype wire

//--- tb/tb_sleep_mode_controller.sv
// self-checking bench for the sleep-mode controller
// assumes slpc_pkg, slpc_top and slpc_monitor are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_sleep_mode_controller;
    localparam int OSC = 8; // shortened crystal start-up
    logic i_clk, i_arst_n, i_wr, i_rd, i_halt_op, i_sys_reset_req;
    logic [1:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic [3:0] fuse;
    logic xtal, lfsel, gie, adc_en;
    logic [4:0] src; // other, adc done, addr match, t2 ovf, lower pin
    logic stall, take, rvec, cpu_en, io_en, adc_ck, osc_en, tosc_en;
    logic adc_go, cmp_pwr;
    logic [2:0] rsv [3] = '{3'h4, 3'h5, 3'h7};
    int errors = 0, total_checks = 0, lat, base;

    slpc_top #(.P_OSC_STARTUP_CK(OSC)) u_dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_halt_op(i_halt_op), .i_sys_reset_req(i_sys_reset_req),
        .o_core_stall(stall), .o_irq_take(take), .o_reset_vector(rvec),
        .i_clock_source_fuses(fuse), .i_crystal_opt(xtal),
        .i_lowfreq_timer_ext_clock_sel(lfsel), .i_global_irq_en(gie),
        .i_adc_enabled(adc_en), .i_ext_irq_upper_is_level(4'h0),
        .i_ext_irq_lower_lines({3'h0, src[4]}),
        .i_ext_irq_upper_lines(4'h0), .i_twi_addr_match(src[2]),
        .i_timer2_ovf(src[3]), .i_timer2_cmp(1'h0), .i_mem_ready_irq(1'h0),
        .i_adc_done_irq(src[1]), .i_cmp_irq(1'h0), .i_other_irq(src[0]),
        .o_cpu_clk_en(cpu_en), .o_flash_clk_en(), .o_io_clk_en(io_en),
        .o_adc_clk_en(adc_ck), .o_asy_clk_en(), .o_main_osc_en(osc_en),
        .o_timer_osc_en(tosc_en), .o_adc_start(adc_go),
        .o_cmp_power_en(cmp_pwr));

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", e, o_rdata);
    endtask
    // arm, pick mode and pulse the halt opcode right after the write
    task automatic go(input logic [2:0] m, input logic arm, input logic e);
        wr(2'h0, {4'h0, m, arm});
        i_halt_op <= 1'b1;
        @(posedge i_clk);
        i_halt_op <= 1'b0;
        #1;
        chk("stall", {7'h0, e}, {7'h0, stall});
    endtask
    // bounded wait for the handler pulse, edges counted in lat
    task automatic wake(input logic [4:0] s);
        src <= s;
        lat = 0;
        while (take !== 1'b1 && lat < 60) begin
            @(posedge i_clk);
            #1;
            lat++;
        end
        src <= 5'h0;
    endtask
    // source that must not wake; left high until the next wake call replaces it
    task automatic hold(input logic [4:0] s);
        src <= s;
        repeat (20) @(posedge i_clk);
        #1;
        chk("asleep", 8'h01, {7'h0, stall});
    endtask
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {i_arst_n, i_wr, i_rd, i_halt_op, i_sys_reset_req} = 5'h0;
        {i_addr, i_wdata, fuse, src} = 19'h0;
        {xtal, lfsel, gie, adc_en} = 4'h0;
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(2'h0, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'hfb);
        rd(2'h0, 8'h0b);
        go(3'h0, 1'b0, 1'b0);
        foreach (rsv[i]) begin
            go(rsv[i], 1'b1, 1'b0);
        end
        adc_en <= 1'b1;
        go(3'h0, 1'b1, 1'b1);
        chk("idle", 8'h07, {4'h0, cpu_en, io_en, adc_ck, adc_go});
        wake(5'h01);
        base = lat;
        chk("halt", 8'(slpc_pkg::HALT_CK + 1), 8'(lat));
        rd(2'h0, 8'h01);
        go(3'h1, 1'b1, 1'b1);
        chk("noise", 8'h03, {4'h0, cpu_en, io_en, adc_ck, adc_go});
        hold(5'h01);
        wake(5'h02);
        chk("lat_noise", 8'(base), 8'(lat));
        wr(2'h1, 8'h03);
        @(posedge i_clk);
        #1;
        chk("cmp", 8'h00, {7'h0, cmp_pwr});
        gie <= 1'b1;
        go(3'h2, 1'b1, 1'b1);
        chk("pdown", 8'h00, {6'h0, osc_en, adc_ck});
        hold(5'h09);
        wake(5'h04);
        chk("lat_pdown", 8'(base + 6), 8'(lat));
        fuse <= 4'h1;
        go(3'h2, 1'b1, 1'b1);
        wake(5'h10);
        chk("lat_fuse", 8'(base + OSC + 2), 8'(lat));
        fuse <= 4'h0;
        lfsel <= 1'b1;
        go(3'h3, 1'b1, 1'b1);
        chk("psave", 8'h01, {6'h0, osc_en, tosc_en});
        wake(5'h08);
        chk("lat_psave", 8'(base + 6), 8'(lat));
        xtal <= 1'b1;
        go(3'h6, 1'b1, 1'b1);
        chk("standby", 8'h01, {7'h0, osc_en});
        wake(5'h04);
        chk("lat_stby", 8'(base + 6), 8'(lat));
        go(3'h2, 1'b1, 1'b1);
        i_sys_reset_req <= 1'b1;
        @(posedge i_clk);
        i_sys_reset_req <= 1'b0;
        #1;
        chk("rstvec", 8'h02, {6'h0, rvec, stall});
        end_of_test();
    end

    // watchdog far past the run's length
    initial begin
        #50000;
        errors++;
        end_of_test();
    end
endmodule

bind slpc_top slpc_monitor u_mon (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_halt_op(i_halt_op), .i_sys_reset_req(i_sys_reset_req),
    .i_adc_enabled(i_adc_enabled), .i_crystal_opt(i_crystal_opt),
    .o_core_stall(o_core_stall), .o_irq_take(o_irq_take),
    .o_reset_vector(o_reset_vector), .o_cpu_clk_en(o_cpu_clk_en),
    .o_io_clk_en(o_io_clk_en), .o_adc_clk_en(o_adc_clk_en),
    .o_main_osc_en(o_main_osc_en), .o_adc_start(o_adc_start));
`default_nettype wire
